// File: src/ata_cfg_consts.svh
// byte addresses, field positions, reset values and timing for the drive config decoder
`ifndef ATA_CFG_CONSTS_SVH
`define ATA_CFG_CONSTS_SVH

// ==========================================
// configuration byte addresses
`define ADDR_DRIVE_RESET_CFG 8'h05
`define ADDR_UDMA_MODE_CFG 8'h06
`define ADDR_PIO_DMA_MODE_CFG 8'h07

// ==========================================
// reset values, loaded until the loader writes the bytes
`define RST_DRIVE_RESET_CFG 8'h07
`define RST_UDMA_MODE_CFG 8'hD4
`define RST_PIO_DMA_MODE_CFG 8'h07

// ==========================================
// field positions
`define BIT_SKIP_PIN_RESET 0
`define BIT_SRST_EN 1
`define BIT_ATA_UDMA_EN 7
`define BIT_ATAPI_UDMA_EN 6
`define BIT_UDMA_M4 4
`define BIT_UDMA_M3 3
`define BIT_UDMA_M2 2
`define BIT_MWDMA_EN 2
`define BIT_PIO_M4 1
`define BIT_PIO_M3 0

// ==========================================
// timing
`define CLK_MHZ 125
`define PIN_RESET_HOLD_NS 25000
`define PIN_RESET_HOLD_CYC ((`PIN_RESET_HOLD_NS * `CLK_MHZ + 999) / 1000)
`define HOLD_CNT_W 12

`endif

// File: src/ata_cfg_pkg.sv
// types shared by the drive reset and transfer mode decoder
package ata_cfg_pkg;

   // ==========================================
   // drive capability, as reported by the attached drive
   typedef struct packed {
      logic is_atapi;
      logic udma_m4;
      logic udma_m3;
      logic udma_m2;
      logic mwdma;
      logic pio_m4;
      logic pio_m3;
   } drive_caps_t;

   // ==========================================
   // chosen transfer setting
   typedef enum logic [1:0] {
      PROTO_PIO,
      PROTO_MWDMA,
      PROTO_UDMA
   } proto_t;

   typedef struct packed {
      proto_t proto;
      logic [2:0] mode;
   } xfer_sel_t;

   // ==========================================
   // configuration byte write from the EEPROM loader
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } cfg_wr_t;

endpackage

// File: src/ata_reset_and_transfer_mode_config.sv
// drive reset sequencing and transfer mode selection from stored configuration bytes
//
// Behaviour
// - drive_reset_config set issues a software reset during drive init; cleared, none.
// - skip pin reset set: reset pin only on the first init after chip reset.
// - skip pin reset clear: reset pin asserted on every drive reset.
// - udma_mode_config plus capable ata drive: use udma at highest rate.
// - atapi udma enable plus capable atapi drive: use udma at highest rate.
// - udma mask bits 4,3,2 enable modes 4,3,2; only those modes exist.
// - udma mode is highest mode enabled in mask and supported by drive.
// - multiword dma enable plus drive support selects multiword dma transfers when no udma mode applies.
// - pio mask bit 1 enables pio mode 4, bit 0 pio mode 3.
// - run highest pio mode enabled and supported; only modes 0, 3, 4.
// - pio mode 0 is always available as fallback.
`timescale 1ns/100ps
`default_nettype none
`include "ata_cfg_consts.svh"

module ata_reset_and_transfer_mode_config (
   input wire logic clk,
   input wire logic resetn,
   input wire ata_cfg_pkg::cfg_wr_t cfg_wr,
   input wire logic [7:0] cfg_rd_addr,
   output logic [7:0] cfg_rd_data,
   input wire logic init_req,
   input wire ata_cfg_pkg::drive_caps_t drive_caps,
   input wire logic srst_done,
   output logic drive_hard_reset_pin_n,
   output logic srst_req,
   output logic init_busy,
   output logic init_done,
   output ata_cfg_pkg::xfer_sel_t xfer_sel
);
   import ata_cfg_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PIN_RESET,
      ST_SRST,
      ST_DONE
   } init_state_t;

   localparam logic [`HOLD_CNT_W-1:0] HOLD_LAST = `HOLD_CNT_W'(`PIN_RESET_HOLD_CYC - 1);

   logic [7:0] drive_reset_cfg_q;
   logic [7:0] udma_mode_cfg_q;
   logic [7:0] pio_dma_mode_cfg_q;
   logic first_init_q;
   init_state_t state_q;
   logic [`HOLD_CNT_W-1:0] hold_cnt_q;
   logic use_pin;
   xfer_sel_t xfer_d;
   logic srst_en;
   logic skip_pin;
   logic udma_on;
   logic pin_low_d;

   // ==========================================
   // decoded fields
   assign srst_en = drive_reset_cfg_q[`BIT_SRST_EN];
   assign skip_pin = drive_reset_cfg_q[`BIT_SKIP_PIN_RESET];
   // enable chosen by drive class; an atapi drive never inherits the ata one
   assign udma_on = drive_caps.is_atapi ? udma_mode_cfg_q[`BIT_ATAPI_UDMA_EN]
                                        : udma_mode_cfg_q[`BIT_ATA_UDMA_EN];

   // ==========================================
   // configuration bytes
   // reserved bits are stored as written; the decode below never looks at them,
   // so a loader that breaks the zero-fill convention only changes readback
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drive_reset_cfg_q <= `RST_DRIVE_RESET_CFG;
         udma_mode_cfg_q <= `RST_UDMA_MODE_CFG;
         pio_dma_mode_cfg_q <= `RST_PIO_DMA_MODE_CFG;
      end else if (cfg_wr.valid) begin
         case (cfg_wr.addr)
            `ADDR_DRIVE_RESET_CFG: drive_reset_cfg_q <= cfg_wr.data;
            `ADDR_UDMA_MODE_CFG: udma_mode_cfg_q <= cfg_wr.data;
            `ADDR_PIO_DMA_MODE_CFG: pio_dma_mode_cfg_q <= cfg_wr.data;
            default: ;
         endcase
      end
   end

   // readback lags the address by one cycle, like a registered rom port
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_rd_data <= 8'h00;
      end else begin
         case (cfg_rd_addr)
            `ADDR_DRIVE_RESET_CFG: cfg_rd_data <= drive_reset_cfg_q;
            `ADDR_UDMA_MODE_CFG: cfg_rd_data <= udma_mode_cfg_q;
            `ADDR_PIO_DMA_MODE_CFG: cfg_rd_data <= pio_dma_mode_cfg_q;
            default: cfg_rd_data <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // reset method choice
   // the forbidden combination (no srst, pin skipped) is not repaired here:
   // after the first init such a drive simply gets no reset at all
   assign use_pin = !skip_pin
                    || first_init_q;

   // cleared only after a whole init, so a skip bit loaded before the first
   // init cannot suppress the power-up pin reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         first_init_q <= 1'b1;
      end else if (state_q == ST_DONE) begin
         first_init_q <= 1'b0;
      end
   end

   // ==========================================
   // drive init sequencer: pin reset, then software reset, then done
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         hold_cnt_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // restart in idle so an abandoned hold cannot shorten the next one
               hold_cnt_q <= '0;
               if (init_req) begin
                  if (use_pin) begin
                     state_q <= ST_PIN_RESET;
                  end else if (srst_en) begin
                     state_q <= ST_SRST;
                  end else begin
                     state_q <= ST_DONE;
                  end
               end
            end
            ST_PIN_RESET: begin
               if (hold_cnt_q == HOLD_LAST) begin
                  hold_cnt_q <= '0;
                  if (srst_en) begin
                     state_q <= ST_SRST;
                  end else begin
                     state_q <= ST_DONE;
                  end
               end else begin
                  hold_cnt_q <= hold_cnt_q + `HOLD_CNT_W'(1);
               end
            end
            ST_SRST: begin
               // no time limit: a drive that never answers keeps init_busy high,
               // so the reset engine must always report back
               if (srst_done) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // pin low from the accepting edge through the last count of the hold
   assign pin_low_d = (state_q == ST_IDLE && init_req && use_pin)
                      || (state_q == ST_PIN_RESET && hold_cnt_q != HOLD_LAST);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drive_hard_reset_pin_n <= 1'b1;
         srst_req <= 1'b0;
         init_busy <= 1'b0;
         init_done <= 1'b0;
      end else begin
         drive_hard_reset_pin_n <= !pin_low_d;
         srst_req <= (state_q == ST_SRST) && !srst_done;
         init_busy <= (state_q == ST_IDLE) ? init_req : (state_q != ST_DONE);
         init_done <= (state_q == ST_DONE);
      end
   end

   // ==========================================
   // transfer mode choice, highest enabled and supported
   always_comb begin
      // pio settled first; any usable dma choice below overrides it
      xfer_d.proto = PROTO_PIO;
      xfer_d.mode = 3'h0;
      if (pio_dma_mode_cfg_q[`BIT_PIO_M4] && drive_caps.pio_m4) begin
         xfer_d.mode = 3'h4;
      end else if (pio_dma_mode_cfg_q[`BIT_PIO_M3] && drive_caps.pio_m3) begin
         xfer_d.mode = 3'h3;
      end
      if (udma_on && udma_mode_cfg_q[`BIT_UDMA_M4] && drive_caps.udma_m4) begin
         xfer_d.proto = PROTO_UDMA;
         xfer_d.mode = 3'h4;
      end else if (udma_on && udma_mode_cfg_q[`BIT_UDMA_M3] && drive_caps.udma_m3) begin
         xfer_d.proto = PROTO_UDMA;
         xfer_d.mode = 3'h3;
      end else if (udma_on && udma_mode_cfg_q[`BIT_UDMA_M2] && drive_caps.udma_m2) begin
         xfer_d.proto = PROTO_UDMA;
         xfer_d.mode = 3'h2;
      // multiword dma reported as mode 2, the only one the data path has
      end else if (pio_dma_mode_cfg_q[`BIT_MWDMA_EN] && drive_caps.mwdma) begin
         xfer_d.proto = PROTO_MWDMA;
         xfer_d.mode = 3'h2;
      end
   end

   // follows config and drive_caps every cycle; hold both steady during a transfer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         xfer_sel <= '{proto: PROTO_PIO, mode: 3'h0};
      end else begin
         xfer_sel <= xfer_d;
      end
   end

endmodule
`default_nettype wire

// File: bench/ata_cfg_sva.sv
// assertion checker for the drive reset and transfer mode decoder
`timescale 1ns/100ps
`default_nettype none
`include "ata_cfg_consts.svh"
module ata_cfg_sva (
   input wire logic clk,
   input wire logic resetn,
   input wire logic init_req,
   input wire ata_cfg_pkg::drive_caps_t drive_caps,
   input wire logic srst_done,
   input wire logic drive_hard_reset_pin_n,
   input wire logic srst_req,
   input wire logic init_busy,
   input wire logic init_done,
   input wire ata_cfg_pkg::xfer_sel_t xfer_sel
);
   import ata_cfg_pkg::*;
   localparam int HOLD = `PIN_RESET_HOLD_CYC;
   logic [12:0] lowc_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // pin low span, too long for a repetition
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lowc_q <= 13'h0000;
      end else if (!drive_hard_reset_pin_n) begin
         lowc_q <= lowc_q + 13'h0001;
      end else begin
         lowc_q <= 13'h0000;
      end
   end
   sequence s_srst_end;
      !srst_req ##1 (init_done && !init_busy);
   endsequence
   // ==========================================
   // reset sequencing
   a_pin_hold: assert property ($rose(drive_hard_reset_pin_n) |-> lowc_q == HOLD)
      else $error("pin low span wrong");
   a_pin_cause: assert property ($fell(drive_hard_reset_pin_n) |-> $past(init_req))
      else $error("pin fell without init request");
   a_srst_hold: assert property (srst_req && !srst_done |=> srst_req)
      else $error("soft reset request dropped early");
   a_srst_end: assert property (srst_req && srst_done |=> s_srst_end)
      else $error("soft reset end sequence wrong");
   a_busy_start: assert property (init_req && !init_busy && !init_done |=> init_busy)
      else $error("init not started");
   // ==========================================
   // transfer selection
   a_udma_mode: assert property (xfer_sel.proto == PROTO_UDMA |-> xfer_sel.mode inside {3'h2, 3'h3, 3'h4})
      else $error("bad udma mode");
   a_udma_cap: assert property (xfer_sel == {PROTO_UDMA, 3'h4} |-> $past(drive_caps.udma_m4))
      else $error("udma mode 4 without support");
   a_mwdma_mode: assert property (xfer_sel.proto == PROTO_MWDMA |-> xfer_sel.mode == 3'h2 && $past(drive_caps.mwdma))
      else $error("bad multiword dma selection");
   a_pio_mode: assert property (xfer_sel.proto == PROTO_PIO |-> xfer_sel.mode inside {3'h0, 3'h3, 3'h4})
      else $error("bad pio mode");
endmodule
bind ata_reset_and_transfer_mode_config ata_cfg_sva i_sva (.clk, .resetn, .init_req, .drive_caps,
   .srst_done, .drive_hard_reset_pin_n, .srst_req, .init_busy, .init_done, .xfer_sel);
`default_nettype wire

// File: bench/ata_drive_model.sv
// behavioural drive answering software reset requests after a set latency
`timescale 1ns/100ps
`default_nettype none
module ata_drive_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic srst_req,
   input wire logic [3:0] lat,
   output logic srst_done
);
   logic [3:0] wait_q;
   // one pulse per request, so a stale done cannot end the next one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_q <= 4'h0;
         srst_done <= 1'b0;
      end else begin
         srst_done <= srst_req && !srst_done && wait_q == lat;
         wait_q <= (srst_req && !srst_done) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// File: bench/test_ata_reset_and_transfer_mode_config.sv
// self-checking bench for the drive reset and transfer mode decoder
`timescale 1ns/100ps
`default_nettype none
`include "ata_cfg_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_ata_reset_and_transfer_mode_config;
   import ata_cfg_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   cfg_wr_t cfg_wr = '0;
   logic [7:0] cfg_rd_addr = 8'h00;
   logic [7:0] cfg_rd_data;
   logic init_req = 1'b0;
   drive_caps_t drive_caps = 7'h3F;
   logic srst_done, drive_hard_reset_pin_n, srst_req, init_busy, init_done;
   xfer_sel_t xfer_sel;
   logic [3:0] lat = 4'h0;
   int mismatches = 0;
   int checks = 0;
   // {udma byte, pio/dma byte, drive caps, expected selection}
   localparam logic [27:0] TAB [10] = '{{8'hD4, 8'h07, 7'h3F, 5'h14}, {8'h8C, 8'h07, 7'h3F, 5'h13},
      {8'hD4, 8'h07, 7'h1F, 5'h12}, {8'h54, 8'h07, 7'h3F, 5'h0A}, {8'h54, 8'h07, 7'h7F, 5'h14},
      {8'hD4, 8'h07, 7'h43, 5'h04}, {8'h00, 8'h03, 7'h3F, 5'h04}, {8'h00, 8'h01, 7'h3F, 5'h03},
      {8'h00, 8'h02, 7'h3D, 5'h00}, {8'h00, 8'h00, 7'h3F, 5'h00}};
   always #4 clk = ~clk;
   ata_reset_and_transfer_mode_config i_dut (.clk, .resetn, .cfg_wr, .cfg_rd_addr, .cfg_rd_data,
      .init_req, .drive_caps, .srst_done, .drive_hard_reset_pin_n, .srst_req, .init_busy,
      .init_done, .xfer_sel);
   ata_drive_model i_drive (.clk, .resetn, .srst_req, .lat, .srst_done);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cfg_wr <= {1'b1, a, d};
      @(posedge clk);
      cfg_wr.valid <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      cfg_rd_addr <= a;
      repeat (2) @(posedge clk);
      #1 `CHK(cfg_rd_data, e)
   endtask
   task automatic init(input int pin_cyc, input logic exp_srst);
      int low = 0;
      logic seen = 1'b0;
      logic done = 1'b0;
      @(posedge clk);
      init_req <= 1'b1;
      @(posedge clk);
      init_req <= 1'b0;
      for (int n = 0; n < 5000 && !done; n++) begin
         #1;
         low += (drive_hard_reset_pin_n === 1'b0);
         seen |= (srst_req === 1'b1);
         done = (init_done === 1'b1);
         @(posedge clk);
      end
      `CHK(low, pin_cyc)
      `CHK(seen, exp_srst)
      `CHK(done, 1'b1)
   endtask
   task test_done;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #(8 * 30000);
      mismatches++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h05, 8'h07);
      rd(8'h06, 8'hD4);
      rd(8'h07, 8'h07);
      rd(8'h10, 8'h00);
      foreach (TAB[i]) begin
         wr(8'h06, TAB[i][27:20]);
         wr(8'h07, TAB[i][19:12]);
         drive_caps <= TAB[i][11:5];
         repeat (3) @(posedge clk);
         #1 `CHK(xfer_sel, TAB[i][4:0])
      end
      init(`PIN_RESET_HOLD_CYC, 1'b1);
      lat <= 4'hF;
      init(0, 1'b1);
      wr(8'h05, 8'h02);
      rd(8'h05, 8'h02);
      init(`PIN_RESET_HOLD_CYC, 1'b1);
      wr(8'h05, 8'h00);
      init(`PIN_RESET_HOLD_CYC, 1'b0);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h05, 8'h07);
      init(`PIN_RESET_HOLD_CYC, 1'b1);
      test_done();
   end
endmodule
`default_nettype wire
